// File: rtl/icw_line_sync.sv
// Synchroniser and edge finder for the I2C clock and data lines
`timescale 1ns/10ps

module icw_line_sync (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rst_n,
   // Raw lines
   input  wire logic          scl_in,
   input  wire logic          sda_in,
   // Events
   output icw_pkg::icw_bus_t  bus
);

   logic [1:0] scl_meta;
   logic [1:0] sda_meta;
   logic       scl_q;
   logic       sda_q;

   // ********************************************************
   // Two-stage synchronisers, then one history stage
   // ********************************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         scl_meta <= 2'b11;
         sda_meta <= 2'b11;
         scl_q    <= 1'b1;
         sda_q    <= 1'b1;
      end else begin
         scl_meta <= {scl_meta[0], scl_in};
         sda_meta <= {sda_meta[0], sda_in};
         scl_q    <= scl_meta[1];
         sda_q    <= sda_meta[1];
      end
   end

   always_comb begin
      bus.rise  = scl_meta[1] & ~scl_q;
      bus.fall  = ~scl_meta[1] & scl_q;
      bus.start = scl_meta[1] & scl_q & sda_q & ~sda_meta[1];
      bus.stop  = scl_meta[1] & scl_q & ~sda_q & sda_meta[1];
      bus.sda   = sda_meta[1];
   end

endmodule

// File: rtl/icw_pkg.sv
// Package: constants and carrier types of the I2C configuration write slave
package icw_pkg;

   // ********************************************************
   // Addressing and command decode
   // ********************************************************
   localparam logic [3:0] ADDR_HIGH     = 4'b1101;
   localparam logic [2:0] OP_WRITE      = 3'b011;
   localparam logic [4:0] PORT_MAX      = 5'h05;
   localparam int         OP_LSB        = 0;
   localparam int         PSEL_HI_LSB   = 0;
   localparam int         PSEL_LO_BIT   = 7;
   localparam int         BE_LSB        = 2;
   localparam int         AHI_LSB       = 0;
   localparam logic [2:0] CMD_BYTES     = 3'h4;
   localparam logic [2:0] DATA_BYTES    = 3'h4;
   localparam logic [2:0] LAST_BIT      = 3'h7;

   // ********************************************************
   // Reset values and timing
   // ********************************************************
   localparam logic [31:0] DATA_RESET   = 32'h0000_0000;
   localparam logic [11:0] ADDR_RESET   = 12'h000;
   localparam int          CLK_NS       = 40;
   localparam int          HOLD_NS      = 300;
   localparam int          HOLD_CYC     = (HOLD_NS + CLK_NS - 1) / CLK_NS;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_CMD  = 3'b010,
      ST_DATA = 3'b011,
      ST_ACK  = 3'b100,
      ST_SKIP = 3'b101
   } icw_state_t;

   // One decoded register write, handed to the configuration space
   typedef struct packed {
      logic [4:0]  port;
      logic [11:0] addr;
      logic [3:0]  be;
      logic [31:0] data;
   } icw_write_t;

   // Bus events found by the edge detector, with the synchronised SDA level
   typedef struct packed {
      logic start;
      logic stop;
      logic rise;
      logic fall;
      logic sda;
   } icw_bus_t;

endpackage

// File: rtl/icw_slave.sv
// I2C slave that writes switch port configuration registers
`timescale 1ns/10ps

module icw_slave (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rst_n,
   // I2C pins
   input  wire logic          scl_in,
   input  wire logic          sda_in,
   output logic               sda_out,
   output logic               sda_oe,
   // Address select pins
   input  wire logic [2:0]    addr_sel,
   // Configuration write port
   output icw_pkg::icw_write_t wr,
   output logic               wr_valid
);

   icw_pkg::icw_bus_t  bus;
   icw_pkg::icw_state_t state;
   logic [2:0]         sel_meta0;
   logic [2:0]         sel;
   logic [7:0]         shreg;
   logic [2:0]         bitcnt;
   logic [2:0]         bytecnt;
   logic               in_data;
   logic               ack_me;
   logic [7:0]         cmd0;
   logic [7:0]         cmd1;
   logic [7:0]         cmd2;
   logic [7:0]         cmd3;
   logic [31:0]        data;
   logic [6:0]         my_addr;
   logic [7:0]         byte_in;
   logic               cmd_ok;
   logic               addr_done;
   logic               ack_hold;

   icw_line_sync u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .bus   (bus)
   );

   // ********************************************************
   // Address select pins, synchronised
   // ********************************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sel_meta0 <= 3'h0;
         sel       <= 3'h0;
      end else begin
         sel_meta0 <= addr_sel;
         sel       <= sel_meta0;
      end
   end

   assign my_addr = {icw_pkg::ADDR_HIGH, sel};
   assign byte_in = {shreg[6:0], bus.sda};

   // Reserved bits of cmd0..cmd2 are never looked at
   assign cmd_ok = (cmd0[2:0] == icw_pkg::OP_WRITE)
                 && ({cmd1[3:0], cmd2[7]} <= icw_pkg::PORT_MAX);

   // ********************************************************
   // Bit and byte sequencer
   // ********************************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state     <= icw_pkg::ST_IDLE;
         shreg     <= 8'h00;
         bitcnt    <= 3'h0;
         bytecnt   <= 3'h0;
         in_data   <= 1'b0;
         addr_done <= 1'b0;
         ack_me    <= 1'b0;
         ack_hold  <= 1'b0;
         cmd0      <= 8'h00;
         cmd1      <= 8'h00;
         cmd2      <= 8'h00;
         cmd3      <= 8'h00;
         data      <= icw_pkg::DATA_RESET;
      end else if (bus.start) begin
         state     <= icw_pkg::ST_ADDR;
         bitcnt    <= 3'h0;
         bytecnt   <= 3'h0;
         in_data   <= 1'b0;
         addr_done <= 1'b0;
         ack_me    <= 1'b0;
         ack_hold  <= 1'b0;
      end else if (bus.stop) begin
         state     <= icw_pkg::ST_IDLE;
         ack_me    <= 1'b0;
         ack_hold  <= 1'b0;
      end else begin
         case (state)
            icw_pkg::ST_ADDR, icw_pkg::ST_CMD, icw_pkg::ST_DATA: begin
               if (bus.rise) begin
                  shreg  <= byte_in;
                  bitcnt <= bitcnt + 3'h1;
                  if (bitcnt == icw_pkg::LAST_BIT) begin
                     state    <= icw_pkg::ST_ACK;
                     ack_hold <= 1'b0;
                     if (state == icw_pkg::ST_ADDR) begin
                        // Reads are not served by this block
                        ack_me <= (byte_in == {my_addr, 1'b0});
                     end else if (state == icw_pkg::ST_CMD) begin
                        ack_me <= 1'b1;
                        case (bytecnt[1:0])
                           2'd0: cmd0 <= byte_in;
                           2'd1: cmd1 <= byte_in;
                           2'd2: cmd2 <= byte_in;
                           default: cmd3 <= byte_in;
                        endcase
                     end else begin
                        ack_me <= (bytecnt < icw_pkg::DATA_BYTES);
                        if (bytecnt < icw_pkg::DATA_BYTES) begin
                           data <= {data[23:0], byte_in};
                        end
                     end
                  end
               end
            end
            icw_pkg::ST_ACK: begin
               // First SCL fall opens the ack bit, the second closes it;
               // SDA must not move while SCL is high or a STOP is faked
               if (bus.fall && !ack_hold) begin
                  ack_hold <= 1'b1;
               end else if (bus.fall) begin
                  ack_hold <= 1'b0;
                  if (!ack_me) begin
                     state <= icw_pkg::ST_SKIP;
                  end else if (!addr_done) begin
                     addr_done <= 1'b1;
                     state     <= icw_pkg::ST_CMD;
                  end else if (in_data) begin
                     bytecnt <= bytecnt + 3'h1;
                     state   <= icw_pkg::ST_DATA;
                  end else if (bytecnt == icw_pkg::CMD_BYTES - 3'h1) begin
                     in_data <= 1'b1;
                     bytecnt <= 3'h0;
                     state   <= icw_pkg::ST_DATA;
                  end else begin
                     bytecnt <= bytecnt + 3'h1;
                     state   <= icw_pkg::ST_CMD;
                  end
               end
            end
            default: ;
         endcase
      end
   end

   // ********************************************************
   // Acknowledge drive, held until SCL falls after the ack bit
   // ********************************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sda_oe  <= 1'b0;
         sda_out <= 1'b1;
      end else begin
         sda_out <= 1'b0;
         if (bus.start || bus.stop || state != icw_pkg::ST_ACK) begin
            sda_oe <= 1'b0;
         end else if (bus.fall) begin
            // Pull low from the fall after bit 8 to the fall after ack
            sda_oe <= ack_me && !ack_hold;
         end
      end
   end

   // ********************************************************
   // Register write issue on STOP after four data bytes
   // ********************************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_valid <= 1'b0;
         wr       <= '0;
      end else begin
         wr_valid <= 1'b0;
         if (bus.stop && in_data && bytecnt >= icw_pkg::DATA_BYTES
             && cmd_ok) begin
            wr_valid <= 1'b1;
            wr.port  <= {cmd1[3:0], cmd2[icw_pkg::PSEL_LO_BIT]};
            wr.be    <= cmd2[5:2];
            wr.addr  <= {cmd2[1:0], cmd3, 2'b00};
            wr.data  <= data;
         end
      end
   end

   // ********************************************************
   // Checks
   // ********************************************************
   a_write_opcode: assert property (@(posedge clk) disable iff (!rst_n)
      wr_valid |-> $past(cmd0[2:0]) == icw_pkg::OP_WRITE)
      else $error("write issued without write opcode");
   a_port_range: assert property (@(posedge clk) disable iff (!rst_n)
      wr_valid |-> wr.port <= icw_pkg::PORT_MAX)
      else $error("port select out of range");
   a_port_form: assert property (@(posedge clk) disable iff (!rst_n)
      wr_valid |-> wr.port == {$past(cmd1[3:0]), $past(cmd2[7])})
      else $error("port select misformed");
   a_addr_low: assert property (@(posedge clk) disable iff (!rst_n)
      wr_valid |-> wr.addr[1:0] == 2'b00)
      else $error("address low bits not zero");
   a_be_form: assert property (@(posedge clk) disable iff (!rst_n)
      wr_valid |-> wr.be == $past(cmd2[5:2]))
      else $error("byte enables misplaced");
   a_no_extra_ack: assert property (@(posedge clk) disable iff (!rst_n)
      (in_data && bytecnt >= icw_pkg::DATA_BYTES
       && state == icw_pkg::ST_ACK) |-> !ack_me)
      else $error("extra data byte acknowledged");
   a_one_pulse: assert property (@(posedge clk) disable iff (!rst_n)
      wr_valid |=> !wr_valid)
      else $error("write strobe longer than one cycle");
   a_ack_low: assert property (@(posedge clk) disable iff (!rst_n)
      sda_oe |-> !sda_out && state == icw_pkg::ST_ACK && ack_me)
      else $error("ack driven high");
   c_write_done: cover property (@(posedge clk) disable iff (!rst_n)
      wr_valid && wr.be == 4'hF);
   c_partial_be: cover property (@(posedge clk) disable iff (!rst_n)
      wr_valid && wr.be != 4'hF);
   c_extra_byte: cover property (@(posedge clk) disable iff (!rst_n)
      state == icw_pkg::ST_SKIP && in_data);

endmodule

// File: verification/i2c_config_register_write_test.sv
// Self-checking bench of the I2C configuration write slave
`timescale 1ns/10ps

module i2c_config_register_write_test;
   logic                clk;
   logic                rst_n;
   logic                scl;
   logic                sda_drv;
   logic                sda_line;
   logic                sda_out;
   logic                sda_oe;
   logic [2:0]          addr_sel;
   icw_pkg::icw_write_t wr;
   logic                wr_valid;
   int                  err_total;
   int                  check_count;
   int                  cyc;
   logic [4:0]          p;
   logic [2:0]          s;

   // Wired-AND of both parties with the pull-up
   assign sda_line = ~(~sda_drv | (sda_oe & ~sda_out));

   icw_slave i_icw_slave (.clk(clk), .rst_n(rst_n), .scl_in(scl),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
      .addr_sel(addr_sel), .wr(wr), .wr_valid(wr_valid));
   icw_bus_master i_icw_bus_master (.clk(clk), .scl(scl),
      .sda_drv(sda_drv), .sda_line(sda_line));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ************************************************************
   // Checking and closing
   // ************************************************************
   task automatic check(input logic [63:0] seen, exp, input string what);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s %h not %h", $time, what, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Cut a hang short well above the ~20000 cycles the tests need
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         finish_test();
      end
   end

   function automatic icw_pkg::icw_write_t exp_wr(logic [31:0] c, d);
      exp_wr.port = {c[19:16], c[15]};
      exp_wr.be = c[13:10];
      exp_wr.addr = {c[9:8], c[7:0], 2'b00};
      exp_wr.data = d;
   endfunction

   // One packet: acks[10] address, [9:6] command, [5:1] data bytes
   task automatic run(input string name, input logic [2:0] sel,
         input logic [6:0] sa, input logic [31:0] c, d, input int nd,
         input logic [10:0] ack_exp, input logic wr_exp);
      logic [10:0]         acks;
      logic                seen;
      icw_pkg::icw_write_t got;
      acks = '0;
      seen = 1'b0;
      addr_sel = sel;
      repeat (4) @(negedge clk);
      i_icw_bus_master.start_bit();
      i_icw_bus_master.put_byte({sa, 1'b0}, acks[10]);
      for (int i = 0; i < 4; i++) begin
         i_icw_bus_master.put_byte(c[31-8*i -: 8], acks[9-i]);
      end
      for (int i = 0; i < nd; i++) begin
         i_icw_bus_master.put_byte(d[31-8*(i%4) -: 8], acks[5-i]);
      end
      i_icw_bus_master.stop_bit();
      repeat (20) @(negedge clk) begin
         if (wr_valid === 1'b1) begin
            seen = 1'b1;
            got = wr;
         end
      end
      check(acks, ack_exp, "acks");
      check(seen, wr_exp, "write pulse");
      if (seen && wr_exp) check(got, exp_wr(c, d), "write");
      $display("test %s done", name);
   endtask

   initial begin
      rst_n = 1'b0;
      addr_sel = 3'h0;
      err_total = 0;
      check_count = 0;
      cyc = 0;
      void'($urandom(62684));
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      run("example", 3'h0, 7'h68, 32'h0300_3C3E, 32'h1234_5678, 4,
          11'h7FC, 1'b1);
      for (int k = 0; k < 16; k++) begin
         p = 5'($urandom_range(0, 5));
         s = 3'($urandom);
         // Reserved bits random: the decoder must ignore them
         run("random", s, {4'b1101, s}, {5'($urandom), 3'b011,
             4'($urandom), p[4:1], p[0], 7'($urandom), 8'($urandom)},
             $urandom, 4, 11'h7FC, 1'b1);
      end
      for (int op = 0; op < 8; op++) begin
         if (op != 3) run("bad opcode", 3'h0, 7'h68,
             {29'h0000_003C, 3'(op)} << 24 | 32'h0000_3C3E,
             32'hA5A5_5A5A, 4, 11'h7FC, 1'b0);
      end
      run("port 6", 3'h0, 7'h68, 32'h0303_3C00, $urandom, 4,
          11'h7FC, 1'b0);
      run("port 31", 3'h0, 7'h68, 32'h030F_BC00, $urandom, 4,
          11'h7FC, 1'b0);
      run("wrong address", 3'h2, 7'h68, 32'h0300_3C3E, $urandom, 4,
          11'h000, 1'b0);
      // Fifth byte is refused, the four acked bytes still commit
      run("five data", 3'h0, 7'h68, 32'h0300_3C3E, $urandom, 5,
          11'h7FC, 1'b1);
      run("three data", 3'h5, 7'h6D, 32'h0300_3C3E, $urandom, 3,
          11'h7F8, 1'b0);
      finish_test();
   end
endmodule

// File: verification/icw_bus_master.sv
// Behavioural I2C bus master that frames register write packets
`timescale 1ns/10ps

module icw_bus_master (
   // Clock
   input  wire logic clk,
   // Bus lines, SDA as open drain with pull-up
   output logic      scl,
   output logic      sda_drv,
   input  wire logic sda_line
);
   // ************************************************************
   // Bus timing: one SCL period is eight clocks, 320 ns
   // ************************************************************
   // SCL stands high between frames, it never runs free
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic start_bit();
      sda_drv = 1'b0;
      wait_clk(4);
      scl = 1'b0;
      wait_clk(2);
   endtask

   // Data changes only while SCL is low; the line is read late in high
   task automatic put_bit(input logic b, output logic s);
      sda_drv = b;
      wait_clk(2);
      scl = 1'b1;
      wait_clk(3);
      s = sda_line;
      wait_clk(1);
      scl = 1'b0;
      wait_clk(2);
   endtask

   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(b[i], s);
      end
      put_bit(1'b1, s);
      ack = ~s;
   endtask

   // Returns at once so the bench sees the commit pulse after STOP
   task automatic stop_bit();
      sda_drv = 1'b0;
      wait_clk(2);
      scl = 1'b1;
      wait_clk(3);
      sda_drv = 1'b1;
   endtask
endmodule
